// file: rtl/ptl_pkg.sv
package ptl_pkg;

  // ----------------------------------------------------------------------
  // Memory-type codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] TYPE_UNCACHEABLE = 3'h0;
  localparam logic [2:0] TYPE_WRITE_COMBINING = 3'h1;
  localparam logic [2:0] TYPE_WRITETHROUGH = 3'h4;
  localparam logic [2:0] TYPE_WRITE_PROTECT = 3'h5;
  localparam logic [2:0] TYPE_WRITEBACK = 3'h6;
  localparam logic [2:0] TYPE_UNCACHEABLE_MINUS = 3'h7;

  // Effective type adds the cache-disabled type at the unused code 2.
  localparam logic [2:0] EFF_CACHE_DISABLED = 3'h2;

  // ----------------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------------
  localparam int FIELD_COUNT = 8;
  localparam int FIELD_WIDTH = 8;
  localparam int CODE_WIDTH = 3;
  localparam logic [63:0] TABLE_RESET = 64'h0007_0406_0007_0406;
  localparam logic [63:0] RESERVED_MASK = 64'hf8f8_f8f8_f8f8_f8f8;

  // ----------------------------------------------------------------------
  // Entry bit positions
  // ----------------------------------------------------------------------
  localparam int SMALL_PAGE_ATTR_BIT = 7;
  localparam int LARGE_PAGE_ATTR_BIT = 12;
  localparam int CACHE_DISABLE_BIT = 4;
  localparam int WRITETHROUGH_BIT = 3;
  localparam int FEATURE_FLAG_BIT = 16;

  // ----------------------------------------------------------------------
  // Entry kinds
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PTL_ENTRY_SMALL_PAGE = 2'b00,
    PTL_ENTRY_LARGE_PAGE = 2'b01,
    PTL_ENTRY_UPPER = 2'b10
  } ptl_entry_kind_t;

endpackage

// file: rtl/ptl_if.sv
`timescale 1ns/1ps
// Carries one lookup between the top and the merge stage.
interface ptl_if;
  logic [2:0] table_type;
  logic [2:0] range_type;
  logic [2:0] eff_type;

  modport top (output table_type, output range_type, input eff_type);
  modport merge (input table_type, input range_type, output eff_type);
endinterface

// file: rtl/ptl_merge.sv
`timescale 1ns/1ps
module ptl_merge (
  ptl_if.merge m
);

  // ----------------------------------------------------------------------
  // Table and range merge
  // ----------------------------------------------------------------------
  // Undefined pairs fall to the cache-disabled code 2; unknown table codes fall to uncacheable.
  always_comb begin
    m.eff_type = ptl_pkg::TYPE_UNCACHEABLE;
    unique case (m.table_type)
      ptl_pkg::TYPE_UNCACHEABLE: begin
        m.eff_type = (m.range_type == ptl_pkg::TYPE_UNCACHEABLE) ?
          ptl_pkg::TYPE_UNCACHEABLE : ptl_pkg::EFF_CACHE_DISABLED;
      end
      ptl_pkg::TYPE_UNCACHEABLE_MINUS: begin
        if (m.range_type == ptl_pkg::TYPE_UNCACHEABLE) begin
          m.eff_type = ptl_pkg::TYPE_UNCACHEABLE;
        end else if (m.range_type == ptl_pkg::TYPE_WRITE_COMBINING) begin
          m.eff_type = ptl_pkg::TYPE_WRITE_COMBINING;
        end else begin
          m.eff_type = ptl_pkg::EFF_CACHE_DISABLED;
        end
      end
      ptl_pkg::TYPE_WRITE_COMBINING: begin
        m.eff_type = ptl_pkg::TYPE_WRITE_COMBINING;
      end
      ptl_pkg::TYPE_WRITE_PROTECT: begin
        unique case (m.range_type)
          ptl_pkg::TYPE_UNCACHEABLE: m.eff_type = ptl_pkg::TYPE_UNCACHEABLE;
          ptl_pkg::TYPE_WRITE_PROTECT: m.eff_type = ptl_pkg::TYPE_WRITE_PROTECT;
          ptl_pkg::TYPE_WRITEBACK: m.eff_type = ptl_pkg::TYPE_WRITE_PROTECT;
          default: m.eff_type = ptl_pkg::EFF_CACHE_DISABLED;
        endcase
      end
      ptl_pkg::TYPE_WRITETHROUGH: begin
        unique case (m.range_type)
          ptl_pkg::TYPE_UNCACHEABLE: m.eff_type = ptl_pkg::TYPE_UNCACHEABLE;
          ptl_pkg::TYPE_WRITETHROUGH: m.eff_type = ptl_pkg::TYPE_WRITETHROUGH;
          ptl_pkg::TYPE_WRITEBACK: m.eff_type = ptl_pkg::TYPE_WRITETHROUGH;
          default: m.eff_type = ptl_pkg::EFF_CACHE_DISABLED;
        endcase
      end
      ptl_pkg::TYPE_WRITEBACK: begin
        m.eff_type = m.range_type;
      end
      default: begin
        m.eff_type = ptl_pkg::TYPE_UNCACHEABLE;
      end
    endcase
  end

endmodule

// file: rtl/ptl_top.sv
// Overview of operation
// - One 64-bit register holds eight attribute fields, numbered zero to seven.
// - Codes: 0 uncacheable, 1 write-combining, 4 writethrough, 5 protect, 6 writeback, 7 minus.
// - Uncacheable-minus acts as uncacheable, except a write-combining range type overrides it.
// - Writes with any reserved bit set fault and leave the register unchanged.
// - Writes carrying an unsupported type code in any field fault.
// - Reset loads writeback, writethrough, uncacheable-minus, uncacheable into 0-3 and 4-7.
// - Index is table bit high, cache-disable middle, writethrough low.
// - Table bit is bit 7 of small pages, bit 12 of large; else zero.
// - Cache-disable index bit is entry bit 4, writethrough bit is bit 3.
// - The lookup is always active; no control bit turns it off.
// - Feature flags report table support by setting bit 16.
// - Each translated access captures the index and applies the selected type.
// - Upper-level fetches index with two bits only, reaching the first four fields.
// - Table uncacheable and uncacheable-minus merge with the range type; table write-combining ignores it.
// - Table write-protect, writethrough and writeback merge with the range type.
// - Disabled range registers give uncacheable; undefined pairs give the cache-disabled type.
// - No cross-processor consistency check is made; software keeps them consistent.
// - Uncacheable is never cached, combined or speculated; write-combining may combine.
// - Writethrough reads allocate shared, write misses skip allocation, hits write both.
// - Write-protect reads allocate shared, writes reach memory, write hits invalidate.
// - Writeback reads allocate shared or exclusive, write misses allocate modified.
//
`timescale 1ns/1ps
module ptl_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr_en,
  input wire logic [63:0] reg_wr_data,
  output logic [63:0] reg_rd_data,
  output logic general_protection_fault,
  output logic [31:0] feature_flags_result,
  input wire logic lookup_valid,
  input wire logic [63:0] entry_data,
  input wire ptl_pkg::ptl_entry_kind_t entry_kind,
  input wire logic range_enable,
  input wire logic [2:0] range_type,
  output logic result_valid,
  output logic [2:0] eff_type,
  output logic [2:0] index_out,
  output logic allow_cache,
  output logic allow_combine,
  output logic allow_speculate,
  output logic read_alloc_shared,
  output logic read_alloc_exclusive,
  output logic write_alloc_modified,
  output logic write_to_memory,
  output logic write_hit_invalidate
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [63:0] page_memory_type_table_reg;
  logic write_reject;
  logic [ptl_pkg::FIELD_COUNT-1:0] field_bad;

  // Every field is checked for a supported code in parallel.
  genvar gi;
  generate
    for (gi = 0; gi < ptl_pkg::FIELD_COUNT; gi++) begin : g_chk
      logic [2:0] code;
      assign code = reg_wr_data[gi*ptl_pkg::FIELD_WIDTH +: ptl_pkg::CODE_WIDTH];
      assign field_bad[gi] = (code == 3'h2) || (code == 3'h3);
    end
  endgenerate

  // A write is refused on any reserved bit or unsupported code.
  assign write_reject = (|(reg_wr_data & ptl_pkg::RESERVED_MASK)) || (|field_bad);

  // The table register itself; refused writes leave it untouched.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_memory_type_table_reg <= ptl_pkg::TABLE_RESET;
    end else if (reg_wr_en && !write_reject) begin
      page_memory_type_table_reg <= reg_wr_data;
    end
  end

  // Fault pulse follows the refused write by one cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      general_protection_fault <= 1'b0;
    end else begin
      general_protection_fault <= reg_wr_en && write_reject;
    end
  end

  assign reg_rd_data = page_memory_type_table_reg;

  // Support bit is constant; the lookup has no enable to clear.
  assign feature_flags_result = 32'h0000_0001 << ptl_pkg::FEATURE_FLAG_BIT;

  // ----------------------------------------------------------------------
  // Index formation
  // ----------------------------------------------------------------------
  logic attr_bit;
  logic [2:0] index_next;

  // Upper-level entries have no table bit, so they see only fields 0-3.
  always_comb begin
    attr_bit = 1'b0;
    unique case (entry_kind)
      ptl_pkg::PTL_ENTRY_SMALL_PAGE: attr_bit = entry_data[ptl_pkg::SMALL_PAGE_ATTR_BIT];
      ptl_pkg::PTL_ENTRY_LARGE_PAGE: attr_bit = entry_data[ptl_pkg::LARGE_PAGE_ATTR_BIT];
      ptl_pkg::PTL_ENTRY_UPPER: attr_bit = 1'b0;
      default: attr_bit = 1'b0;
    endcase
    index_next = {attr_bit, entry_data[ptl_pkg::CACHE_DISABLE_BIT],
                  entry_data[ptl_pkg::WRITETHROUGH_BIT]};
  end

  // ----------------------------------------------------------------------
  // Field selection and merge
  // ----------------------------------------------------------------------
  logic [2:0] table_type;
  logic [2:0] range_used;
  logic [2:0] merged;
  ptl_if mif ();

  assign table_type = page_memory_type_table_reg[index_next*ptl_pkg::FIELD_WIDTH +:
                                                 ptl_pkg::CODE_WIDTH];
  // Disabled range registers report uncacheable.
  assign range_used = range_enable ? range_type : ptl_pkg::TYPE_UNCACHEABLE;
  assign mif.table_type = table_type;
  assign mif.range_type = range_used;
  assign merged = mif.eff_type;

  ptl_merge u_merge (
    .m(mif.merge)
  );

  // Capture the result for the access path; one cycle of latency.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_valid <= 1'b0;
      eff_type <= ptl_pkg::TYPE_UNCACHEABLE;
      index_out <= 3'h0;
    end else begin
      result_valid <= lookup_valid;
      if (lookup_valid) begin
        eff_type <= merged;
        index_out <= index_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cache behaviour per effective type
  // ----------------------------------------------------------------------
  // Cache-disabled and unknown codes behave as uncacheable here.
  always_comb begin
    allow_cache = 1'b0;
    allow_combine = 1'b0;
    allow_speculate = 1'b0;
    read_alloc_shared = 1'b0;
    read_alloc_exclusive = 1'b0;
    write_alloc_modified = 1'b0;
    write_to_memory = 1'b1;
    write_hit_invalidate = 1'b0;
    unique case (eff_type)
      ptl_pkg::TYPE_WRITE_COMBINING: begin
        allow_combine = 1'b1;
        allow_speculate = 1'b1;
      end
      ptl_pkg::TYPE_WRITETHROUGH: begin
        allow_cache = 1'b1;
        allow_speculate = 1'b1;
        read_alloc_shared = 1'b1;
      end
      ptl_pkg::TYPE_WRITE_PROTECT: begin
        allow_cache = 1'b1;
        allow_speculate = 1'b1;
        read_alloc_shared = 1'b1;
        write_hit_invalidate = 1'b1;
      end
      ptl_pkg::TYPE_WRITEBACK: begin
        allow_cache = 1'b1;
        allow_speculate = 1'b1;
        read_alloc_shared = 1'b1;
        read_alloc_exclusive = 1'b1;
        write_alloc_modified = 1'b1;
        write_to_memory = 1'b0;
      end
      default: begin
        allow_cache = 1'b0;
      end
    endcase
  end

  // No state here watches other processors; consistency is software's job.

endmodule

// file: tb/ptl_walker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Walker model: builds one page entry
// ----------------------------------------
module ptl_walker (
  input wire logic [2:0] idx,
  input wire ptl_pkg::ptl_entry_kind_t kind,
  input wire logic [63:0] noise,
  output logic [63:0] entry_data
);
  // Junk fills every unused bit, so reading a wrong bit picks a wrong field.
  always_comb begin
    entry_data = noise;
    entry_data[4] = idx[1];
    entry_data[3] = idx[0];
    if (kind == ptl_pkg::PTL_ENTRY_SMALL_PAGE)
      entry_data[7] = idx[2];
    if (kind == ptl_pkg::PTL_ENTRY_LARGE_PAGE)
      entry_data[12] = idx[2];
  end
endmodule

// file: tb/ptl_top_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the lookup block
// ----------------------------------------
module ptl_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr_en,
  input wire logic [63:0] reg_wr_data,
  input wire logic [63:0] reg_rd_data,
  input wire logic general_protection_fault,
  input wire logic [31:0] feature_flags_result,
  input wire logic lookup_valid,
  input wire logic [63:0] entry_data,
  input wire ptl_pkg::ptl_entry_kind_t entry_kind,
  input wire logic result_valid,
  input wire logic [2:0] eff_type,
  input wire logic [2:0] index_out,
  input wire logic allow_cache,
  input wire logic allow_combine,
  input wire logic allow_speculate,
  input wire logic write_alloc_modified
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // A write is refused for a reserved bit or for code 2 or 3 in a field.
  function automatic logic bad(logic [63:0] d);
    for (int i = 0; i < 8; i++)
      if (d[8*i+1 +: 2] == 2'b01)
        return 1'b1;
    return (d & ptl_pkg::RESERVED_MASK) != 64'h0;
  endfunction
  AST_TAKE: assert property (lookup_valid |=> result_valid)
    else $error("lookup gave no result");
  AST_IDLE: assert property (!lookup_valid |=> !result_valid && $stable(eff_type))
    else $error("result without lookup");
  AST_IDX: assert property (lookup_valid |=> index_out[1:0] == $past(entry_data[4:3]))
    else $error("low index bits wrong");
  AST_ATTR: assert property (lookup_valid && entry_kind == ptl_pkg::PTL_ENTRY_SMALL_PAGE
    |=> index_out[2] == $past(entry_data[7]))
    else $error("small page index bit wrong");
  AST_LARGE: assert property (lookup_valid && entry_kind == ptl_pkg::PTL_ENTRY_LARGE_PAGE
    |=> index_out[2] == $past(entry_data[12]))
    else $error("large page index bit wrong");
  AST_UPPER: assert property (lookup_valid && entry_kind == ptl_pkg::PTL_ENTRY_UPPER
    |=> !index_out[2])
    else $error("upper level used high field");
  AST_WR: assert property (reg_wr_en && !bad(reg_wr_data)
    |=> reg_rd_data == $past(reg_wr_data) && !general_protection_fault)
    else $error("good write not stored");
  AST_REFUSE: assert property (reg_wr_en && bad(reg_wr_data)
    |=> general_protection_fault && $stable(reg_rd_data))
    else $error("bad write not refused");
  AST_PULSE: assert property (!reg_wr_en |=> !general_protection_fault)
    else $error("fault without write");
  AST_FLAG: assert property (feature_flags_result == 32'h0001_0000)
    else $error("support flag wrong");
  AST_UNCACHED: assert property (eff_type == ptl_pkg::TYPE_UNCACHEABLE
    |-> !allow_cache && !allow_combine && !allow_speculate)
    else $error("uncacheable decode wrong");
  AST_WRBACK: assert property (eff_type == ptl_pkg::TYPE_WRITEBACK
    |-> allow_cache && write_alloc_modified)
    else $error("writeback decode wrong");
endmodule
bind ptl_top ptl_chk chk (.clk, .nrst, .reg_wr_en, .reg_wr_data, .reg_rd_data,
  .general_protection_fault, .feature_flags_result, .lookup_valid, .entry_data,
  .entry_kind, .result_valid, .eff_type, .index_out, .allow_cache, .allow_combine,
  .allow_speculate, .write_alloc_modified);

// file: tb/ptl_top_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the lookup block
// ----------------------------------------
module ptl_top_bench;
  logic clk, nrst, reg_wr_en, lookup_valid, range_enable, result_valid, gpf;
  logic [63:0] reg_wr_data, reg_rd_data, entry_data, tbl, noise;
  logic [31:0] feature_flags_result, seed;
  logic [2:0] range_type, eff_type, index_out, idx;
  ptl_pkg::ptl_entry_kind_t kind;
  logic [13:0] exp_q[$];
  wire [7:0] beh;
  int error_cnt, checks_done;
  ptl_walker walker (.idx(idx), .kind(kind), .noise(noise), .entry_data(entry_data));
  ptl_top uut (.clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .general_protection_fault(gpf),
    .feature_flags_result(feature_flags_result), .lookup_valid(lookup_valid),
    .entry_data(entry_data), .entry_kind(kind), .range_enable(range_enable),
    .range_type(range_type), .result_valid(result_valid), .eff_type(eff_type),
    .index_out(index_out), .allow_cache(beh[7]), .allow_combine(beh[6]),
    .allow_speculate(beh[5]), .read_alloc_shared(beh[4]), .read_alloc_exclusive(beh[3]),
    .write_alloc_modified(beh[2]), .write_to_memory(beh[1]), .write_hit_invalidate(beh[0]));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
  endfunction
  // Effective type; code 2 stands for the cache-disabled result.
  function automatic logic [2:0] merge(logic [2:0] t, logic [2:0] r);
    case (t)
      3'h1: return 3'h1;
      3'h6: return r;
      3'h7: return (r == 3'h0 || r == 3'h1) ? r : 3'h2;
      3'h5: return (r == 3'h0) ? 3'h0 : (r == 3'h5 || r == 3'h6) ? 3'h5 : 3'h2;
      3'h4: return (r == 3'h0) ? 3'h0 : (r == 3'h4 || r == 3'h6) ? 3'h4 : 3'h2;
      default: return (r == 3'h0) ? 3'h0 : 3'h2;
    endcase
  endfunction
  // Access behaviour per effective type: cache, combine, speculate, shared,
  // exclusive, modified, write to memory, invalidate on write hit.
  function automatic logic [7:0] behave(logic [2:0] e);
    case (e)
      3'h1: return 8'h62;
      3'h4: return 8'hb2;
      3'h5: return 8'hb3;
      3'h6: return 8'hbc;
      default: return 8'h02;
    endcase
  endfunction
  task automatic cmp(logic [63:0] got, logic [63:0] exp, string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("counts: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // The result of a refused write is held back by one edge, then checked.
  task automatic wr(logic [63:0] d, logic refused);
    @(posedge clk) reg_wr_en <= 1'b1;
    reg_wr_data <= d;
    @(posedge clk) reg_wr_en <= 1'b0;
    if (!refused)
      tbl = d;
    #1 cmp(reg_rd_data, tbl, "table");
    cmp(gpf, refused, "fault");
  endtask
  // Lookups run back to back; the expected result is noted as each is sent.
  task automatic look(int n);
    logic [2:0] i3, rt, ix, e;
    logic [2:0] rc[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
    logic [1:0] k;
    repeat (n) begin
      seed = lfsr(seed);
      i3 = seed[2:0];
      k = (seed[4:3] == 2'd3) ? 2'd2 : seed[4:3];
      rt = rc[seed[10:8] % 5];
      ix = (k < 2'd2) ? i3 : {1'b0, i3[1:0]};
      @(posedge clk) lookup_valid <= 1'b1;
      idx <= i3;
      kind <= ptl_pkg::ptl_entry_kind_t'(k);
      noise <= {seed, ~seed};
      range_enable <= seed[5] | seed[6];
      range_type <= rt;
      e = merge(tbl[8*ix +: 3], (seed[5] | seed[6]) ? rt : 3'h0);
      exp_q.push_back({behave(e), e, ix});
    end
    @(posedge clk) lookup_valid <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Results are taken in the cycle they stand and matched in order.
  always @(posedge clk)
    if (nrst && result_valid === 1'b1) begin
      if (exp_q.size() == 0)
        cmp(1, 0, "extra result");
      else
        cmp({beh, eff_type, index_out}, exp_q.pop_front(), "lookup");
    end
  initial begin
    logic [2:0] vc[6];
    logic [63:0] t;
    vc = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    {nrst, reg_wr_en, lookup_valid, range_enable, idx, range_type} = '0;
    {reg_wr_data, noise} = '0;
    kind = ptl_pkg::PTL_ENTRY_SMALL_PAGE;
    seed = 32'haef5_1587;
    tbl = 64'h0007_0406_0007_0406;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk) #1 cmp(reg_rd_data, tbl, "reset table");
    cmp(feature_flags_result, 64'h0001_0000, "support flag");
    look(64);
    $display("test reset_lookup done");
    wr(64'h0000_0000_0000_0008, 1'b1);
    wr(64'h0002_0000_0000_0000, 1'b1);
    wr(64'h0000_0000_0000_0003, 1'b1);
    $display("test refused_writes done");
    repeat (6) begin
      for (int f = 0; f < 8; f++) begin
        seed = lfsr(seed);
        t[8*f +: 8] = {5'h0, vc[seed[7:0] % 6]};
      end
      wr(t, 1'b0);
      look(40);
    end
    $display("test random_tables done");
    // A second reset in mid-run must bring the default table back.
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    tbl = 64'h0007_0406_0007_0406;
    @(posedge clk) #1 cmp(reg_rd_data, tbl, "table after reset");
    look(16);
    $display("test mid_reset done");
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0)
      cmp(exp_q.size(), 0, "results missing");
    test_done();
  end
endmodule
